//--- hw/sbt_defs.svh
// Register offsets, field positions, reset values and count limits
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// Register word indices on the bus
`define SBT_ADDR_CTRL      4'h0
`define SBT_ADDR_COUNT     4'h1
`define SBT_ADDR_RELOAD    4'h2
`define SBT_ADDR_STATUS    4'h3
`define SBT_ADDR_CAPTURE   4'h4

// Control register fields
`define SBT_CTRL_EN_BIT    0
`define SBT_CTRL_MODE_LSB  1
`define SBT_CTRL_MODE_MSB  3
`define SBT_CTRL_PRES_LSB  4
`define SBT_CTRL_PRES_MSB  6
`define SBT_CTRL_POL_BIT   7
`define SBT_CTRL_OUTEN_BIT 8
`define SBT_CTRL_WIDTH     9

// Status register fields
`define SBT_STAT_OUT_BIT   0
`define SBT_STAT_IN_BIT    1
`define SBT_STAT_OS_BIT    2

// Reset values
`define SBT_CTRL_RESET     9'h000
`define SBT_COUNT_RESET    16'h0001
`define SBT_RELOAD_RESET   16'hffff
`define SBT_COUNT_RESTART  16'h0001
`define SBT_COUNT_WRAP     16'h0000
`define SBT_COUNT_TOP      16'hffff

`endif

//--- hw/sbt_pkg.sv
// Types shared by the sixteen-bit timer
`default_nettype none
package sbt_pkg;
  typedef enum logic [2:0] {
    sbt_mode_one_shot   = 3'h0,
    sbt_mode_continuous = 3'h1,
    sbt_mode_comparator = 3'h2,
    sbt_mode_compare    = 3'h3,
    sbt_mode_gated      = 3'h4
  } sbt_mode_type;
  typedef logic [15:0] sbt_word_type;
endpackage
`default_nettype wire

//--- hw/sbt_sync.sv
// Two-flop synchroniser for one asynchronous level
`default_nettype none
module sbt_sync (
  input  wire logic clk_sys,
  input  wire logic rst_sync_n,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic stage_one;

  // First stage is read only by the second
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage_one <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule
`default_nettype wire

//--- hw/sbt_prescaler.sv
// Prescaler that gives one tick every 2**select system clocks
`default_nettype none
module sbt_prescaler (
  input  wire logic       clk_sys,
  input  wire logic       rst_sync_n,
  input  wire logic       run,
  input  wire logic [2:0] select,
  output logic            tick
);
  logic [6:0] div_count;
  wire  [6:0] div_limit;
  wire  [6:0] next_div_count;

  // Terminal count is 2**select minus one
  assign div_limit      = 7'((8'h01 << select) - 8'h01);
  assign tick           = run && (div_count == div_limit);
  assign next_div_count = (!run || tick) ? 7'h00 : 7'(div_count + 7'h01);

  // Divider state
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_count <= 7'h00;
    end else begin
      div_count <= next_div_count;
    end
  end
endmodule
`default_nettype wire

//--- hw/sbt_timer.sv
// Sixteen-bit multi-mode timer with Avalon-MM register slave
`include "sbt_defs.svh"
`default_nettype none

// Overview of operation
// - Continuous mode counts prescaled ticks up toward the reload value.
// - Continuous reload raises interrupt, sets count to 0001H, keeps counting.
// - Continuous and comparator modes toggle enabled output on every reload.
// - Software start count applies to first pass; later passes start 0001H.
// - Period is reload times prescale; first period reload minus start plus one.
// - Comparator mode counts comparator edges of the polarity-selected sense.
// - Prescaler bypassed in comparator mode; each qualifying edge counts one.
// - Comparator reload raises interrupt, sets 0001H, keeps counting edges.
// - Comparator mode polarity also sets the initial timer output level.
// - Edges since start readable as current count minus start value.
// - Compare match keeps count running and toggles the enabled output.
// - Compare mode wraps FFFFH to 0000H and continues.
// - Compare event after compare minus start plus one, times prescale clocks.
// - One-shot times out after reload minus start plus one, times prescale clocks.
// - Gated mode counts only while input is at polarity-selected level.
// - Gated mode interrupts on input deassertion and on reload.
// - Gated reload interrupts, sets 0001H, resumes, toggles enabled output.
module sbt_timer
  import sbt_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Register bus slave
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // Far-side pins and event output
  input  wire logic         comparator_in,
  input  wire logic         timer_in,
  output logic              timer_out,
  output logic              timer_out_en,
  output logic              timer_event
);
  import sbt_pkg::*;

  // Reset release and input synchronisers
  logic       rst_meta_n;
  logic       rst_sync_n;
  logic       comp_sync;
  logic       gate_sync;

  // Software-visible registers
  logic [`SBT_CTRL_WIDTH-1:0] ctrl;
  sbt_word_type               count;
  sbt_word_type               reload;

  // Internal state
  sbt_word_type               start_value;
  logic                       out_level;
  logic                       comp_prev;
  logic                       gate_prev;
  logic                       one_shot_done;
  logic                       read_pending;

  // Control field decode
  wire                        enable;
  wire sbt_mode_type          mode;
  wire [2:0]                  prescale_sel;
  wire                        polarity;
  wire                        out_enable;

  assign enable       = ctrl[`SBT_CTRL_EN_BIT];
  assign mode         = sbt_mode_type'(ctrl[`SBT_CTRL_MODE_MSB:
                                             `SBT_CTRL_MODE_LSB]);
  assign prescale_sel = ctrl[`SBT_CTRL_PRES_MSB:`SBT_CTRL_PRES_LSB];
  assign polarity     = ctrl[`SBT_CTRL_POL_BIT];
  assign out_enable   = ctrl[`SBT_CTRL_OUTEN_BIT];

  // One-hot view of the mode field
  wire mode_once;
  wire mode_cont;
  wire mode_edges;
  wire mode_cmpr;
  wire mode_gate;
  wire mode_reloads;

  assign mode_once    = (mode == sbt_mode_one_shot);
  assign mode_cont    = (mode == sbt_mode_continuous);
  assign mode_edges   = (mode == sbt_mode_comparator);
  assign mode_cmpr    = (mode == sbt_mode_compare);
  assign mode_gate    = (mode == sbt_mode_gated);
  // Modes that restart at 0001H on reaching reload and keep counting
  assign mode_reloads = mode_cont || mode_edges || mode_gate;

  // Write strobe for one register word
  function automatic logic wr_hit(input logic       wr,
                                  input logic [3:0] addr,
                                  input logic [3:0] target);
    return wr && (addr == target);
  endfunction

  // Merge bytes of a write into an existing word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  lanes);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // Release reset through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Comparator output crosses into the clock domain
  sbt_sync u_comp_sync (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .async_in   (comparator_in),
    .sync_out   (comp_sync)
  );

  // Timer input pin crosses into the clock domain
  sbt_sync u_gate_sync (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .async_in   (timer_in),
    .sync_out   (gate_sync)
  );

  // Gate level and comparator edge qualification
  wire gate_active;
  wire gate_fall;
  wire comp_edge;
  wire comp_rise;
  wire comp_fall;

  assign gate_active = (gate_sync == polarity);
  assign gate_fall   = enable && mode_gate &&
                       (gate_prev == polarity) && !gate_active;
  assign comp_rise   = comp_sync && !comp_prev;
  assign comp_fall   = !comp_sync && comp_prev;
  assign comp_edge   = polarity ? comp_rise : comp_fall;

  // Prescaler runs only while enabled in a system-clock mode
  wire presc_run;
  wire presc_tick;

  assign presc_run = enable && !mode_edges &&
                     !(mode_once && one_shot_done) &&
                     !(mode_gate && !gate_active);

  sbt_prescaler u_prescaler (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .run        (presc_run),
    .select     (prescale_sel),
    .tick       (presc_tick)
  );

  // Count tick source: comparator edge bypasses the prescaler
  wire count_tick;
  assign count_tick = enable &&
                      (mode_edges ? comp_edge
                                                     : presc_tick);

  // Reload, compare and timeout decisions
  wire at_reload;
  wire reload_hit;
  wire compare_hit;
  wire one_shot_hit;

  assign at_reload    = (count == reload);
  // Reload in the restarting modes
  assign reload_hit   = count_tick && at_reload && mode_reloads;
  // Match in compare mode leaves the count running
  assign compare_hit  = count_tick && at_reload && mode_cmpr;
  // Time-out ends a one-shot pass
  assign one_shot_hit = count_tick && at_reload && mode_once;

  // Next count
  sbt_word_type next_count;
  always_comb begin
    next_count = count;
    if (count_tick) begin
      // Restart at 0001H after a reload or a time-out
      if (reload_hit) begin
        next_count = `SBT_COUNT_RESTART;
      end else if (one_shot_hit) begin
        next_count = `SBT_COUNT_RESTART;
      end else if (count == `SBT_COUNT_TOP) begin
        // Free rollover at the top of the count
        next_count = `SBT_COUNT_WRAP;
      end else begin
        next_count = 16'(count + 16'h0001);
      end
    end
  end

  // Bus decode
  wire wr_ctrl;
  wire wr_count;
  wire wr_reload;
  wire rd_now;
  wire ctrl_enabling;

  assign wr_ctrl   = wr_hit(avs_write, avs_address, `SBT_ADDR_CTRL);
  assign wr_count  = wr_hit(avs_write, avs_address, `SBT_ADDR_COUNT);
  assign wr_reload = wr_hit(avs_write, avs_address, `SBT_ADDR_RELOAD);
  assign rd_now    = avs_read && !read_pending;

  // Write data merged into each register
  wire [31:0] ctrl_merged;
  wire [31:0] count_merged;
  wire [31:0] reload_merged;
  assign ctrl_merged   = merge_bytes({23'h0, ctrl}, avs_writedata,
                                     avs_byteenable);
  assign count_merged  = merge_bytes({16'h0, count}, avs_writedata,
                                     avs_byteenable);
  assign reload_merged = merge_bytes({16'h0, reload}, avs_writedata,
                                     avs_byteenable);
  assign ctrl_enabling = wr_ctrl && !enable &&
                         ctrl_merged[`SBT_CTRL_EN_BIT];

  // Output level: set by polarity while disabled, toggles on reload, compare and time-out when output enabled
  logic next_out_level;
  always_comb begin
    next_out_level = out_level;
    if (wr_ctrl && !ctrl_merged[`SBT_CTRL_EN_BIT]) begin
      next_out_level = ctrl_merged[`SBT_CTRL_POL_BIT];
    end else if (out_enable && (reload_hit || compare_hit ||
                                one_shot_hit)) begin
      next_out_level = !out_level;
    end
  end

  // Control and reload registers
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl   <= `SBT_CTRL_RESET;
      reload <= `SBT_RELOAD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_merged[`SBT_CTRL_WIDTH-1:0];
      end else if (one_shot_hit) begin
        ctrl[`SBT_CTRL_EN_BIT] <= 1'b0;
      end
      if (wr_reload) begin
        reload <= reload_merged[15:0];
      end
    end
  end

  // Count and start value; software write only lands while disabled
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count       <= `SBT_COUNT_RESET;
      start_value <= `SBT_COUNT_RESET;
    end else begin
      // Count writes while running are refused
      if (wr_count && !enable) begin
        count       <= count_merged[15:0];
        start_value <= count_merged[15:0];
      end else begin
        count <= next_count;
      end
    end
  end

  // Any interrupt source in this cycle
  wire any_event;
  assign any_event = reload_hit || compare_hit || one_shot_hit ||
                     gate_fall;

  // Event and edge history
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_level     <= 1'b0;
      comp_prev     <= 1'b0;
      gate_prev     <= 1'b0;
      one_shot_done <= 1'b0;
      timer_event   <= 1'b0;
    end else begin
      out_level   <= next_out_level;
      comp_prev   <= comp_sync;
      gate_prev   <= gate_sync;
      timer_event <= any_event;
      // A time-out wins over a fresh enable in the same cycle
      if (one_shot_hit) begin
        one_shot_done <= 1'b1;
      end else if (ctrl_enabling) begin
        one_shot_done <= 1'b0;
      end
    end
  end

  // Status and edge-count words for the read mux
  wire [31:0] status_word;
  wire [15:0] edges_seen;

  assign status_word = {29'h0, one_shot_done, gate_sync, out_level};
  assign edges_seen  = 16'(count - start_value);

  // Read mux
  logic [31:0] read_mux;
  always_comb begin
    case (avs_address)
      `SBT_ADDR_CTRL:    read_mux = {23'h0, ctrl};
      `SBT_ADDR_COUNT:   read_mux = {16'h0, count};
      `SBT_ADDR_RELOAD:  read_mux = {16'h0, reload};
      `SBT_ADDR_STATUS:  read_mux = status_word;
      `SBT_ADDR_CAPTURE: read_mux = {16'h0, edges_seen};
      default:           read_mux = 32'h0000_0000;
    endcase
  end

  // One wait state on reads, none on writes
  assign avs_waitrequest = avs_read && !read_pending;

  // Read data captured in the stalled cycle, shown in the next
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      read_pending <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      read_pending <= rd_now;
      if (rd_now) begin
        avs_readdata <= read_mux;
      end
    end
  end

  assign timer_out    = out_level;
  assign timer_out_en = out_enable;
endmodule
`default_nettype wire

//--- tb/sbt_pins_model.sv
// Behavioural model of the comparator output and the gate pin
`default_nettype none
module sbt_pins_model (
  input  wire logic clk_sys,
  output var  logic comparator_in,
  output var  logic timer_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines idle low until a scenario moves them
  initial begin
    comparator_in = 1'b0;
    timer_in      = 1'b0;
  end

  // Whole comparator pulses, each level held four clocks
  task automatic pulse_cmp(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      comparator_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      comparator_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  // Gate level, changed just after a clock edge
  task automatic set_gate(input logic v);
    @(posedge clk_sys);
    timer_in <= v;
  endtask
endmodule
`default_nettype wire

//--- tb/sbt_timer_asserts.sv
// Port-level assertions for the sixteen-bit timer
`default_nettype none
module sbt_timer_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        timer_out,
  input wire logic        timer_out_en,
  input wire logic        timer_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Decode of software writes
  wire ctrl_wr = avs_write && avs_address == 4'h0 && avs_byteenable[0];
  wire rel_wr  = avs_write && avs_address == 4'h2;
  logic        en_q;
  logic [5:0]  cfg_q;
  logic [15:0] rel_q;
  logic [23:0] gap;
  logic        armed;
  wire  [23:0] period = {8'h00, rel_q} << cfg_q[5:3];

  // Shadow of enable, mode, prescale and reload
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q  <= 1'b0;
      cfg_q <= 6'h00;
      rel_q <= 16'hffff;
    end else if (ctrl_wr) begin
      en_q  <= avs_writedata[0];
      cfg_q <= avs_writedata[6:1];
    end else if (rel_wr) begin
      rel_q <= avs_writedata[15:0];
    end
  end

  // Cycles since the last event; armed once a clean period starts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap   <= 24'h0;
      armed <= 1'b0;
    end else begin
      gap   <= timer_event ? 24'h1 : gap + 24'h1;
      armed <= avs_write ? 1'b0 : (timer_event | armed);
    end
  end

  AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read not stalled in its first cycle");
  AST_RD_ONE: assert property (avs_read && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("read stalled longer than one cycle");
  AST_WR_FREE: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_UNMAP: assert property (avs_read && !avs_waitrequest
    && avs_address > 4'h4 |-> avs_readdata == 32'h0)
    else $error("unmapped word read nonzero");
  AST_OUT_EN: assert property (ctrl_wr && avs_byteenable[1] |=>
    timer_out_en == $past(avs_writedata[8]))
    else $error("output enable does not follow control");
  AST_TOGGLE: assert property ($changed(timer_out) && !$past(ctrl_wr)
    |-> timer_event)
    else $error("output moved without an event");
  AST_QUIET: assert property (!en_q && !$past(en_q)
    |-> !timer_event)
    else $error("event while disabled");
  AST_HOLD_OUT: assert property (!en_q && !ctrl_wr
    |=> $stable(timer_out))
    else $error("output moved while disabled");
  AST_CONT_PERIOD: assert property (timer_event && armed && en_q
    && cfg_q[2:0] == 3'h1 |-> gap == period)
    else $error("continuous period wrong");

  CV_CONT: cover property (timer_event && cfg_q[2:0] == 3'h1);
  CV_CMP: cover property (timer_event && cfg_q[2:0] == 3'h2);
  CV_GATE: cover property (timer_event && cfg_q[2:0] == 3'h4);
endmodule

bind sbt_timer sbt_timer_asserts chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer_out(timer_out), .timer_out_en(timer_out_en),
  .timer_event(timer_event)
);
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the sixteen-bit timer
`default_nettype none
module tb_top
  import sbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [3:0]  wr_be = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        comparator_in;
  logic        timer_in;
  logic        timer_out;
  logic        timer_out_en;
  logic        timer_event;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          ev_cnt = 0;
  int          cyc = 0;
  int          ev_last = 0;
  int          ev_prev = 0;
  int          e0;
  logic [31:0] rd;

  always #12.5 clk_sys = ~clk_sys;

  // Event count and the cycles of the last two events
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (timer_event === 1'b1) begin
      ev_cnt  <= ev_cnt + 1;
      ev_prev <= ev_last;
      ev_last <= cyc;
    end
  end

  sbt_timer uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .comparator_in(comparator_in), .timer_in(timer_in),
    .timer_out(timer_out), .timer_out_en(timer_out_en),
    .timer_event(timer_event)
  );

  sbt_pins_model pins (
    .clk_sys(clk_sys), .comparator_in(comparator_in), .timer_in(timer_in)
  );

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Bounded wait for a rising edge that samples waitrequest low
  task automatic wait_req;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_byteenable <= wr_be;
    avs_write     <= 1'b1;
    wait_req();
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_req();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask

  // Bounded wait until the event count reaches n
  task automatic wait_ev(input int n);
    int k;
    k = 0;
    while (ev_cnt < n && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    if (ev_cnt < n) begin
      error_cnt++;
      finish_test();
    end
  endtask

  function automatic logic [31:0] ctl(input sbt_mode_type m,
    input logic [2:0] p, input logic pol, input logic oe, input logic en);
    return {23'h0, oe, pol, p, m, en};
  endfunction

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h1, 32'h1);
    rd_chk(4'h2, 32'hffff);
    rd_chk(4'h9, 32'h0);
    // Only byte lane 0 of the reload word is written
    wr_be = 4'h1;
    bus_wr(4'h2, 32'h0000_1207);
    wr_be = 4'hf;
    rd_chk(4'h2, 32'hff07);
    // Continuous, prescale 2, reload 4, odd start
    bus_wr(4'h0, ctl(sbt_mode_continuous, 3'h1, 1'b0, 1'b1, 1'b0));
    bus_wr(4'h1, 32'h3);
    bus_wr(4'h2, 32'h4);
    e0 = ev_cnt;
    bus_wr(4'h0, ctl(sbt_mode_continuous, 3'h1, 1'b0, 1'b1, 1'b1));
    wait_ev(e0 + 3);
    chk(timer_out, 1'b1);
    chk(ev_last - ev_prev, 32'h8);
    bus_wr(4'h0, ctl(sbt_mode_continuous, 3'h1, 1'b0, 1'b1, 1'b0));
    bus_rd(4'h1, rd);
    e0 = ev_cnt;
    idle(20);
    rd_chk(4'h1, rd);
    chk(ev_cnt - e0, 32'h0);
    // Compare across the top of the count
    bus_wr(4'h1, 32'hfffe);
    bus_wr(4'h2, 32'h2);
    e0 = ev_cnt;
    bus_wr(4'h0, ctl(sbt_mode_compare, 3'h0, 1'b0, 1'b1, 1'b1));
    wait_ev(e0 + 1);
    idle(2);
    chk(timer_out, 1'b1);
    bus_wr(4'h0, ctl(sbt_mode_compare, 3'h0, 1'b0, 1'b1, 1'b0));
    bus_rd(4'h1, rd);
    chk(rd > 32'h3 && rd < 32'h10, 32'h1);
    // Comparator edges with the slowest prescale set
    bus_wr(4'h0, ctl(sbt_mode_comparator, 3'h7, 1'b1, 1'b1, 1'b0));
    idle(2);
    chk(timer_out, 1'b1);
    bus_wr(4'h1, 32'h1);
    bus_wr(4'h2, 32'h4);
    e0 = ev_cnt;
    bus_wr(4'h0, ctl(sbt_mode_comparator, 3'h7, 1'b1, 1'b1, 1'b1));
    pins.pulse_cmp(2);
    idle(8);
    rd_chk(4'h4, 32'h2);
    rd_chk(4'h1, 32'h3);
    pins.pulse_cmp(2);
    idle(8);
    chk(ev_cnt - e0, 32'h1);
    rd_chk(4'h1, 32'h1);
    chk(timer_out, 1'b0);
    // Gated by a high input
    bus_wr(4'h0, ctl(sbt_mode_gated, 3'h0, 1'b1, 1'b0, 1'b0));
    bus_wr(4'h1, 32'h1);
    bus_wr(4'h2, 32'h100);
    e0 = ev_cnt;
    bus_wr(4'h0, ctl(sbt_mode_gated, 3'h0, 1'b1, 1'b0, 1'b1));
    idle(10);
    rd_chk(4'h1, 32'h1);
    pins.set_gate(1'b1);
    idle(20);
    chk(ev_cnt - e0, 32'h0);
    pins.set_gate(1'b0);
    idle(8);
    chk(ev_cnt - e0, 32'h1);
    bus_rd(4'h1, rd);
    chk(rd > 32'h10 && rd < 32'h30, 32'h1);
    rd_chk(4'h3, 32'h1);
    // One-shot times out once and stops
    bus_wr(4'h0, ctl(sbt_mode_one_shot, 3'h0, 1'b0, 1'b0, 1'b0));
    bus_wr(4'h1, 32'h1);
    bus_wr(4'h2, 32'h6);
    e0 = ev_cnt;
    bus_wr(4'h0, ctl(sbt_mode_one_shot, 3'h0, 1'b0, 1'b0, 1'b1));
    idle(40);
    chk(ev_cnt - e0, 32'h1);
    rd_chk(4'h0, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
